// >>> rtl/urx_pkg.sv
// constants and types for the receive dma channel state block
// Contract
// - hold 30-bit queue front descriptor pointer
// - record first descriptor of current packet
// - packet-in-progress flag at bit zero
// - track descriptor of buffer now filling
// - keep full byte address in buffer
// - count packet bytes, write back at end
// - keep free byte count of current buffer
// - seventh word holds first/current buffer counts
// - skip programmed bytes in first buffer
package urx_pkg;
  localparam int unsigned PADDR_W     = 12;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned PTR_W       = 30;
  localparam int unsigned SKIP_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 2;

  localparam logic [PADDR_W-1:0] OFS_SKIP    = 12'h000;
  localparam logic [PADDR_W-1:0] OFS_HEAD    = 12'h004;
  localparam logic [PADDR_W-1:0] OFS_PKTSTRT = 12'h008;
  localparam logic [PADDR_W-1:0] OFS_CURDESC = 12'h00C;
  localparam logic [PADDR_W-1:0] OFS_BUFADDR = 12'h010;
  localparam logic [PADDR_W-1:0] OFS_LENGTH  = 12'h014;
  localparam logic [PADDR_W-1:0] OFS_BYTECNT = 12'h018;

  localparam int unsigned PTR_LSB    = 2;
  localparam int unsigned IN_PKT_BIT = 0;
  localparam int unsigned HI_LSB     = 16;

  localparam logic [DATA_W-1:0] STATE_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DESC_LEN_OFS = 32'h0000_000C;
  localparam logic [3:0]        STRB_BYTE    = 4'h1;
  localparam logic [3:0]        STRB_LEN     = 4'h3;

  typedef enum logic [1:0] {
    URX_ST_DATA  = 2'b00,
    URX_ST_BYTE  = 2'b01,
    URX_ST_WBACK = 2'b10
  } urx_state_t;
endpackage : urx_pkg

// >>> rtl/urx_stream_if.sv
// valid/ready stream carrier between the channel and its buffer
`timescale 1ns/100ps
interface urx_stream_if #(
  parameter int unsigned W = 9
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : urx_stream_if

// >>> rtl/urx_pair_fifo.sv
// small fifo holding received bytes while memory writes are stalled
`timescale 1ns/100ps
module urx_pair_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  urx_stream_if.snk  in_s,
  urx_stream_if.src  out_s
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             pop;

  assign in_s.ready  = (count_q != CW'(DEPTH));
  assign out_s.valid = (count_q != '0);
  assign out_s.data  = mem_q[rd_ptr_q];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : wrap_inc

  // storage has no reset; only the pointers and the count define what is valid
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_s.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wrap_inc(wr_ptr_q);
      if (pop)  rd_ptr_q <= wrap_inc(rd_ptr_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= CW'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_q <= CW'(count_q - 1'b1);
    end
  end
endmodule : urx_pair_fifo

// >>> rtl/urx_rx_channel.sv
// receive dma channel: state words on apb, byte stream into memory buffers
`timescale 1ns/100ps
module urx_rx_channel (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [urx_pkg::PADDR_W-1:0]   paddr,
  input  wire logic [urx_pkg::DATA_W-1:0]    pwdata,
  output logic      [urx_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          rx_valid,
  input  wire logic [urx_pkg::BYTE_W-1:0]    rx_data,
  input  wire logic                          rx_last,
  output logic                               rx_ready,
  output logic                               mem_valid,
  output logic      [urx_pkg::DATA_W-1:0]    mem_addr,
  output logic      [urx_pkg::DATA_W-1:0]    mem_wdata,
  output logic      [3:0]                    mem_strb,
  input  wire logic                          mem_ready,
  output logic                               in_packet
);
  import urx_pkg::*;

  localparam int unsigned SW = BYTE_W + 1;

  urx_stream_if #(.W(SW)) in_if ();
  urx_stream_if #(.W(SW)) out_if ();

  urx_pair_fifo #(
    .WIDTH (SW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .in_s    (in_if.snk),
    .out_s   (out_if.src)
  );

  assign in_if.data  = {rx_last, rx_data};
  assign in_if.valid = rx_valid;
  assign rx_ready    = in_if.ready;

  logic [SKIP_W-1:0]  skip_q;
  logic [PTR_W-1:0]   head_q;
  logic [PTR_W-1:0]   sop_q;
  logic               in_pkt_q;
  logic [PTR_W-1:0]   cur_desc_q;
  logic [DATA_W-1:0]  buf_addr_q;
  logic [CNT_W-1:0]   pkt_len_q;
  logic [CNT_W-1:0]   free_q;
  logic [CNT_W-1:0]   first_cnt_q;
  logic [CNT_W-1:0]   cur_cnt_q;
  logic               eop_q;
  urx_state_t         state_q;
  logic [DATA_W-1:0]  mem_addr_q;
  logic [DATA_W-1:0]  mem_wdata_q;
  logic [3:0]         mem_strb_q;
  logic [DATA_W-1:0]  prdata_q;
  logic               perr_q;

  logic               setup;
  logic               wr_en;
  logic               first;
  logic               issue;
  logic               done;
  logic               wback_done;
  logic [CNT_W-1:0]   skip16;
  logic [CNT_W-1:0]   eff_free;
  logic [DATA_W-1:0]  eff_addr;
  logic               same_buf;

  function automatic logic hit(input logic [PADDR_W-1:0] a,
                               input logic [PADDR_W-1:0] ofs);
    return a == ofs;
  endfunction : hit

  function automatic logic mapped(input logic [PADDR_W-1:0] a);
    return hit(a, OFS_SKIP) || hit(a, OFS_HEAD) || hit(a, OFS_PKTSTRT) ||
           hit(a, OFS_CURDESC) || hit(a, OFS_BUFADDR) || hit(a, OFS_LENGTH) ||
           hit(a, OFS_BYTECNT);
  endfunction : mapped

  // apb: zero wait states, read data captured in the setup cycle
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && mapped(paddr);
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = psel && penable && perr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= STATE_RST;
      perr_q   <= 1'b0;
    end else if (setup) begin
      perr_q   <= !mapped(paddr);
      prdata_q <= STATE_RST;
      unique case (1'b1)
        hit(paddr, OFS_SKIP):    prdata_q <= {24'h000000, skip_q};
        hit(paddr, OFS_HEAD):    prdata_q <= {head_q, 2'h0};
        hit(paddr, OFS_PKTSTRT): prdata_q <= {sop_q, 1'b0, in_pkt_q};
        hit(paddr, OFS_CURDESC): prdata_q <= {cur_desc_q, 2'h0};
        hit(paddr, OFS_BUFADDR): prdata_q <= buf_addr_q;
        hit(paddr, OFS_LENGTH):  prdata_q <= {pkt_len_q, free_q};
        hit(paddr, OFS_BYTECNT): prdata_q <= {first_cnt_q, cur_cnt_q};
        default:                 prdata_q <= STATE_RST;
      endcase
    end
  end

  // datapath decisions for the byte at the head of the buffer
  assign first    = !in_pkt_q;
  assign skip16   = {8'h00, skip_q};
  assign eff_free = first ? ((free_q > skip16) ? CNT_W'(free_q - skip16) : '0)
                          : free_q;
  assign eff_addr = first ? DATA_W'(buf_addr_q + {24'h000000, skip_q}) : buf_addr_q;
  // an exhausted buffer stalls the stream until software refills the count
  assign issue    = (state_q == URX_ST_DATA) && out_if.valid && (eff_free != '0);
  assign out_if.ready = issue;
  assign done       = mem_valid && mem_ready;
  assign wback_done = done && (state_q == URX_ST_WBACK);
  assign same_buf   = first || (cur_desc_q == sop_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= URX_ST_DATA;
      eop_q   <= 1'b0;
    end else begin
      unique case (state_q)
        URX_ST_DATA: begin
          if (issue) begin
            state_q <= URX_ST_BYTE;
            eop_q   <= out_if.data[BYTE_W];
          end
        end
        URX_ST_BYTE: begin
          if (done) state_q <= eop_q ? URX_ST_WBACK : URX_ST_DATA;
        end
        URX_ST_WBACK: begin
          if (done) begin
            state_q <= URX_ST_DATA;
            eop_q   <= 1'b0;
          end
        end
        default: state_q <= URX_ST_DATA;
      endcase
    end
  end

  assign mem_valid = (state_q != URX_ST_DATA);
  assign mem_addr  = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign mem_strb  = mem_strb_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr_q  <= STATE_RST;
      mem_wdata_q <= STATE_RST;
      mem_strb_q  <= 4'h0;
    end else if (issue) begin
      mem_addr_q  <= eff_addr;
      mem_wdata_q <= {4{out_if.data[BYTE_W-1:0]}};
      mem_strb_q  <= STRB_BYTE << eff_addr[1:0];
    end else if (done && state_q == URX_ST_BYTE && eop_q) begin
      // length goes into the low half of the packet's first descriptor
      mem_addr_q  <= DATA_W'({sop_q, 2'h0} + DESC_LEN_OFS);
      mem_wdata_q <= {16'h0000, pkt_len_q};
      mem_strb_q  <= STRB_LEN;
    end
  end

  // software writes win over hardware updates of the same word, except for the in-packet flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= '0;
    end else if (wr_en && hit(paddr, OFS_SKIP)) begin
      skip_q <= pwdata[SKIP_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_q <= '0;
    end else if (wr_en && hit(paddr, OFS_HEAD)) begin
      head_q <= pwdata[DATA_W-1:PTR_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sop_q <= '0;
    end else if (wr_en && hit(paddr, OFS_PKTSTRT)) begin
      sop_q <= pwdata[DATA_W-1:PTR_LSB];
    end else if (issue && first) begin
      sop_q <= cur_desc_q;
    end
  end

  // the hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_pkt_q <= 1'b0;
    end else if (issue) begin
      in_pkt_q <= 1'b1;
    end else if (wback_done) begin
      in_pkt_q <= 1'b0;
    end else if (wr_en && hit(paddr, OFS_PKTSTRT)) begin
      in_pkt_q <= pwdata[IN_PKT_BIT];
    end
  end
  assign in_packet = in_pkt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_desc_q <= '0;
    end else if (wr_en && hit(paddr, OFS_CURDESC)) begin
      cur_desc_q <= pwdata[DATA_W-1:PTR_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_addr_q <= STATE_RST;
    end else if (wr_en && hit(paddr, OFS_BUFADDR)) begin
      buf_addr_q <= pwdata;
    end else if (issue) begin
      buf_addr_q <= DATA_W'(eff_addr + 32'h0000_0001);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_len_q <= '0;
      free_q    <= '0;
    end else if (wr_en && hit(paddr, OFS_LENGTH)) begin
      pkt_len_q <= pwdata[DATA_W-1:HI_LSB];
      free_q    <= pwdata[CNT_W-1:0];
    end else if (issue) begin
      pkt_len_q <= first ? 16'h0001 : CNT_W'(pkt_len_q + 16'h0001);
      free_q    <= CNT_W'(eff_free - 16'h0001);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_cnt_q <= '0;
      cur_cnt_q   <= '0;
    end else if (wr_en && hit(paddr, OFS_BYTECNT)) begin
      first_cnt_q <= pwdata[DATA_W-1:HI_LSB];
      cur_cnt_q   <= pwdata[CNT_W-1:0];
    end else if (issue) begin
      if (same_buf) begin
        first_cnt_q <= first ? 16'h0001 : CNT_W'(first_cnt_q + 16'h0001);
      end
      cur_cnt_q <= CNT_W'(eff_free - 16'h0001);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a starved engine must hold its place, not skip the byte
  stall_on_empty_a: assert property (
    (state_q == URX_ST_DATA) && (eff_free == '0) && !wr_en
    |=> state_q == URX_ST_DATA && $stable(buf_addr_q))
    else $error("byte taken with no free space");

  free_count_a: assert property (
    issue && !first && !wr_en |=> free_q == CNT_W'($past(free_q) - 16'h0001))
    else $error("free count did not drop by one");

  length_count_a: assert property (
    issue && !first && !wr_en |=> pkt_len_q == CNT_W'($past(pkt_len_q) + 16'h0001))
    else $error("packet length did not grow by one");

  length_wback_a: assert property (
    (state_q == URX_ST_WBACK)
    |-> mem_wdata[CNT_W-1:0] == pkt_len_q && mem_strb == STRB_LEN &&
        mem_addr == DATA_W'({sop_q, 2'h0} + DESC_LEN_OFS))
    else $error("length write-back carries wrong value");

  skip_first_a: assert property (
    issue && first
    |=> mem_addr == DATA_W'($past(buf_addr_q) + {24'h000000, $past(skip_q)}))
    else $error("first byte not placed after skip");

  flag_set_a: assert property (
    issue |=> in_pkt_q ##1 (in_pkt_q || $past(wback_done)))
    else $error("in-packet flag not set by data");

  sop_capture_a: assert property (
    issue && first && !wr_en |=> sop_q == $past(cur_desc_q))
    else $error("first descriptor not recorded");

  addr_step_a: assert property (
    issue && !wr_en |=> buf_addr_q == DATA_W'($past(eff_addr) + 32'h0000_0001))
    else $error("buffer address did not advance");

  reserved_zero_a: assert property (
    setup && hit(paddr, OFS_CURDESC)
    |=> prdata[1:0] == 2'h0 && prdata[DATA_W-1:PTR_LSB] == $past(cur_desc_q))
    else $error("current descriptor readback wrong");

  eop_return_a: assert property (
    (state_q == URX_ST_WBACK) && mem_ready |=> !in_pkt_q && state_q == URX_ST_DATA)
    else $error("packet flag not cleared after write-back");

  // memory may stall for any time, so the request must not drift meanwhile
  mem_hold_a: assert property (
    mem_valid && !mem_ready
    |=> mem_valid && $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_strb))
    else $error("memory request changed while waiting");

  skip_free_a: assert property (
    issue && first && !wr_en
    |=> free_q == CNT_W'($past(free_q) - {8'h00, $past(skip_q)} - 16'h0001))
    else $error("skip not taken from free count");

  first_len_a: assert property (
    issue && first && !wr_en |=> pkt_len_q == 16'h0001)
    else $error("packet length not restarted");

  wback_follows_a: assert property (
    (state_q == URX_ST_BYTE) && done && eop_q |=> state_q == URX_ST_WBACK)
    else $error("no length write-back after last byte");

  byte_strobe_a: assert property (
    (state_q == URX_ST_BYTE) |-> mem_strb == 4'(STRB_BYTE << mem_addr[1:0]))
    else $error("byte lane does not match address");

  head_hold_a: assert property (
    !(wr_en && hit(paddr, OFS_HEAD)) |=> $stable(head_q))
    else $error("queue front pointer changed by itself");

  desc_hold_a: assert property (
    !(wr_en && hit(paddr, OFS_CURDESC)) |=> $stable(cur_desc_q))
    else $error("current descriptor changed by itself");

  sop_hold_a: assert property (
    !(wr_en && hit(paddr, OFS_PKTSTRT)) && !(issue && first) |=> $stable(sop_q))
    else $error("first descriptor changed mid-packet");

  byte_count_a: assert property (
    issue && !first && same_buf && !wr_en
    |=> first_cnt_q == CNT_W'($past(first_cnt_q) + 16'h0001))
    else $error("first buffer count did not grow");

  count_mirror_a: assert property (
    issue && !wr_en |=> cur_cnt_q == free_q)
    else $error("buffer count differs from free count");

  bad_addr_err_a: assert property (
    psel && penable && !mapped(paddr) |-> pslverr)
    else $error("unmapped access not refused");
endmodule : urx_rx_channel

// >>> sim/urx_mem_model.sv
// memory partner: takes channel writes, answers promptly, slowly or not at all
`timescale 1ns/100ps
module urx_mem_model #(
  parameter logic [31:0] SEED = 32'h35FD09C6
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_valid,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [3:0]  mem_strb,
  input  wire logic        hold,
  output logic             mem_ready
);
  logic [31:0] rnd_q;
  logic [7:0]  store [logic [31:0]];

  function automatic logic [31:0] step(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : step

  // ready is random so the channel sees both zero-wait and long waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rnd_q     <= SEED;
      mem_ready <= 1'b0;
    end else begin
      rnd_q     <= step(rnd_q);
      mem_ready <= !hold && rnd_q[0];
    end
  end

  // only strobed lanes land, so a length write-back keeps the upper half
  always @(posedge pclk) begin
    if (mem_valid && mem_ready) begin
      for (int i = 0; i < 4; i++) begin
        if (mem_strb[i]) store[{mem_addr[31:2], 2'(i)}] = mem_wdata[8*i +: 8];
      end
    end
  end
endmodule : urx_mem_model

// >>> sim/tb_top.sv
// self-checking bench for the receive dma channel
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import urx_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, seed;
  logic        rx_valid, rx_last, rx_ready, mem_valid, mem_ready, in_packet, hold;
  logic [7:0]  rx_data;
  logic [3:0]  mem_strb;
  logic [31:0] wa[$], wd[$];
  logic [3:0]  ws[$];
  int          n_errors, check_count;
  localparam logic [11:0] OFS[7] = '{OFS_SKIP, OFS_HEAD, OFS_PKTSTRT, OFS_CURDESC,
                                     OFS_BUFADDR, OFS_LENGTH, OFS_BYTECNT};
  localparam logic [31:0] MSK[7] = '{32'h0000_00FF, 32'hFFFF_FFFC, 32'hFFFF_FFFD,
                                     32'hFFFF_FFFC, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};

  urx_rx_channel dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_valid, .rx_data, .rx_last, .rx_ready, .mem_valid, .mem_addr,
    .mem_wdata, .mem_strb, .mem_ready, .in_packet);
  urx_mem_model mem (.pclk, .presetn, .mem_valid, .mem_addr, .mem_wdata, .mem_strb,
    .hold, .mem_ready);

  always @(posedge pclk) begin
    if (mem_valid && mem_ready) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_wdata);
      ws.push_back(mem_strb);
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // one idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 32'h0, v, e);
  endtask : rd

  task automatic pkt(input logic [7:0] s, input logic [31:0] d, a, input logic [15:0] f,
                     input int n, input logic st);
    logic [7:0]  b[$];
    logic [31:0] v;
    int          k;
    wr(OFS_SKIP, {24'h0, s});
    wr(OFS_CURDESC, d);
    wr(OFS_BUFADDR, a);
    wr(OFS_LENGTH, {16'h0, f});
    wr(OFS_BYTECNT, 32'h0);
    wr(OFS_PKTSTRT, 32'h0);
    wa.delete(); wd.delete(); ws.delete();
    hold <= st;
    fork
      begin
        for (int i = 0; i < n; i++) begin
          v = xs();
          b.push_back(v[7:0]);
          rx_valid <= 1'b1; rx_data <= v[7:0]; rx_last <= (i == n - 1);
          do @(posedge pclk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0; rx_last <= 1'b0;
      end
      if (st) begin
        // memory held off: buffer must fill and refuse, packet stays open
        repeat (20) @(posedge pclk);
        `CHK(rx_ready, 1'b0)
        `CHK(in_packet, 1'b1)
        hold <= 1'b0;
      end
    join
    k = 0;
    while (wa.size() < n + 1 && k < 800) begin
      @(posedge pclk);
      k++;
    end
    repeat (2) @(posedge pclk);
    `CHK(wa.size(), n + 1)
    for (int i = 0; i < n; i++) begin
      v = a + s + i;
      `CHK(wa[i], v)
      `CHK(wd[i], {4{b[i]}})
      `CHK(ws[i], 4'h1 << v[1:0])
      `CHK(mem.store[v], b[i])
    end
    `CHK(wa[n], {d[31:2], 2'b00} + DESC_LEN_OFS)
    `CHK(wd[n], 32'(n))
    `CHK(ws[n], STRB_LEN)
    `CHK(mem.store[{d[31:2], 2'b00} + DESC_LEN_OFS], 8'(n))
    `CHK(in_packet, 1'b0)
    rd(OFS_PKTSTRT, v);
    `CHK(v, {d[31:2], 2'b00})
    rd(OFS_CURDESC, v);
    `CHK(v, {d[31:2], 2'b00})
    rd(OFS_BUFADDR, v);
    `CHK(v, a + s + n)
    rd(OFS_LENGTH, v);
    `CHK(v, {16'(n), f - 16'(s) - 16'(n)})
    rd(OFS_BYTECNT, v);
    `CHK(v, {16'(n), f - 16'(s) - 16'(n)})
    $display("packet test done, skip %0d, %0d bytes", s, n);
  endtask : pkt

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end

  initial begin
    logic [31:0] v, r;
    logic        e;
    seed = 32'h35FD09C6;
    n_errors = 0; check_count = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; rx_valid = 1'b0; rx_data = 8'h00; rx_last = 1'b0; hold = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      rd(OFS[i], v);
      `CHK(v, 32'h0)
    end
    $display("reset values test done");
    // reserved bits: random patterns must come back masked
    repeat (3) for (int i = 0; i < 7; i++) begin
      r = xs();
      wr(OFS[i], r);
      rd(OFS[i], v);
      `CHK(v, r & MSK[i])
    end
    apb(1'b0, 12'h01C, 32'h0, v, e);
    `CHK({e, v}, 33'h1_0000_0000)
    apb(1'b0, 12'h006, 32'h0, v, e);
    `CHK({e, v}, 33'h1_0000_0000)
    $display("register access test done");
    pkt(8'h00, 32'h0000_1000, 32'h0002_0000, 16'h0100, 5, 1'b0);
    r = xs();
    pkt(8'hFF, {r[31:2], 2'b00}, xs(), 16'hFFFF, 7, 1'b1);
    pkt(8'h03, 32'h0000_2004, 32'h0003_0001, 16'h0007, 4, 1'b0);
    // buffer has no free byte left: a new packet must wait in the stream buffer
    wa.delete();
    rx_valid <= 1'b1;
    rx_data  <= 8'hA5;
    rx_last  <= 1'b1;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHK(wa.size(), 0)
    `CHK(in_packet, 1'b0)
    $display("exhausted buffer test done");
    // reset in mid-run drops the waiting byte and clears every word
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(rx_ready, 1'b1)
    for (int i = 0; i < 7; i++) begin
      rd(OFS[i], v);
      `CHK(v, 32'h0)
    end
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule : tb_top
